// ==== adc_selftest_result_defs.svh ====
// register offsets, field positions, reset values and forced settings
`ifndef ADC_SELFTEST_RESULT_DEFS_SVH
`define ADC_SELFTEST_RESULT_DEFS_SVH
`define OFS_SELFTEST_SELECT  8'h00
`define OFS_SWITCH_SELFTEST_RESULT_MODE 8'h04
`define OFS_MEASURE_ENABLE   8'h08
`define OFS_BALANCE_ENABLE   8'h0c
`define OFS_SELFTEST_CONFIG  8'h10
`define OFS_SCAN_CONTROL     8'h14
`define OFS_SHORT_THRESHOLD  8'h18
`define OFS_LOW_THRESHOLD    8'h1c
`define OFS_HIGH_THRESHOLD   8'h20
`define OFS_FAULT_FLAGS      8'h24
`define OFS_SELFTEST_RESULT  8'h28
`define OFS_ACQ_CONTROL      8'h2c
`define OFS_EFFECTIVE_CONFIG 8'h30
`define REG_WORDS            6'd13
`define ALT_PATH_BIT         0
`define POLARITY_BIT         0
`define START_BIT            0
`define BUSY_BIT             0
`define COMPARE_EN_BIT       1
`define EFF_ALT_BIT          15
`define EFF_BIPOLAR_BIT      16
`define MEASURE_ENABLE_RST   15'h0000
`define BALANCE_ENABLE_RST   12'h000
`define THRESHOLD_RST        16'h0000
`define HIGH_THRESHOLD_RST   16'hffff
`define RESULT_RST           16'h0000
`define UPPER_MEAS_FORCE     3'h0
`define SHORT_SWITCH_FORCE   12'h000
`define ODD_SWITCH_SET       12'h555
`define EVEN_SWITCH_SET      12'haaa
`define SWITCH_COUNT         4'd12
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// ==== adc_selftest_result_pkg.sv ====
// types shared by the diagnostic sequencer and its comparator
package adc_selftest_result_pkg;
    typedef enum logic [2:0] {
        ST_NONE = 3'h0, ST_ALT_REF = 3'h1, ST_SUPPLY = 3'h2, ST_AMP_OFFSET = 3'h3,
        ST_ZERO_SCALE = 3'h4, ST_FULL_SCALE = 3'h5, ST_DIE_TEMP = 3'h6, ST_SPARE = 3'h7
    } selftest_sel_t;
    typedef enum logic [2:0] {
        SW_OFF = 3'h0, SW_SHORT = 3'h1, SW_OPEN = 3'h2, SW_SPARE3 = 3'h3,
        SW_SPARE4 = 3'h4, SW_SENSE_ODD = 3'h5, SW_SENSE_EVEN = 3'h6, SW_SPARE7 = 3'h7
    } switch_mode_t;
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b01,
        ACQ_BUSY = 2'b10
    } acq_state_t;
endpackage : adc_selftest_result_pkg

// ==== selftest_result_cmp_if.sv ====
// carrier between the sequencer and the switch fault comparator
`timescale 1ns/10ps
interface selftest_result_cmp_if;
    import adc_selftest_result_pkg::*;
    logic         sample_valid;
    logic [3:0]   sample_channel;
    logic [15:0]  sample_volts;
    switch_mode_t mode;
    logic [15:0]  short_thr;
    logic [15:0]  low_thr;
    logic [15:0]  high_thr;
    logic [11:0]  switch_enable;
    logic [11:0]  fault_set;
    modport src (output sample_valid, sample_channel, sample_volts, mode, short_thr,
                 low_thr, high_thr, switch_enable, input fault_set);
    modport chk (input sample_valid, sample_channel, sample_volts, mode, short_thr,
                 low_thr, high_thr, switch_enable, output fault_set);
endinterface : selftest_result_cmp_if

// ==== switch_fault_check.sv ====
// per-switch threshold comparison for the balancing switch diagnostics
`timescale 1ns/10ps
`include "adc_selftest_result_defs.svh"
module switch_fault_check
    import adc_selftest_result_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    selftest_result_cmp_if.chk  cmp
);
    logic [11:0] set_r;
    logic [11:0] set_nxt;
    logic        hit;

    // one-cycle set pulse for the switch the sample belongs to
    always_comb begin
        hit = 1'b0;
        unique case (cmp.mode)
            SW_SHORT: hit = cmp.sample_volts < cmp.short_thr;
            SW_OPEN: hit = cmp.switch_enable[cmp.sample_channel]
                           && (cmp.sample_volts > cmp.high_thr
                               || cmp.sample_volts < cmp.low_thr);
            SW_SENSE_ODD, SW_SENSE_EVEN: hit = cmp.sample_volts > cmp.high_thr
                                               || cmp.sample_volts < cmp.low_thr;
            default: hit = 1'b0; // off and spare codes compare nothing
        endcase
        set_nxt = 12'h000;
        // channels past the last switch carry no flag
        if (cmp.sample_valid && hit && cmp.sample_channel < `SWITCH_COUNT) begin
            set_nxt[cmp.sample_channel] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) set_r <= 12'h000;
        else set_r <= set_nxt;
    end
    assign cmp.fault_set = set_r;

    property p_short_low;
        @(posedge clk) disable iff (!reset_n)
        cmp.sample_valid && cmp.mode == SW_SHORT && cmp.sample_channel < 4'd12
            && cmp.sample_volts < cmp.short_thr
            |=> cmp.fault_set == (12'h001 << $past(cmp.sample_channel));
    endproperty
    a_short_low: assert property (p_short_low) else $error("short fault not flagged");

    property p_open_window;
        @(posedge clk) disable iff (!reset_n)
        cmp.sample_valid && cmp.mode == SW_OPEN && cmp.sample_volts <= cmp.high_thr
            && cmp.sample_volts >= cmp.low_thr |=> cmp.fault_set == 12'h000;
    endproperty
    a_open_window: assert property (p_open_window) else $error("in-window open flagged");
endmodule : switch_fault_check

// ==== adc_and_balance_switch_diagnostics.sv ====
// ADC self-test and balancing switch diagnostic sequencer with AXI4-Lite registers
//
// How it works
// - select 1 measures the alternate reference; result captured while the acquisition is busy
// - select 2 converts scaled reference against thermistor bias reference
// - select 3 shorts amplifier inputs and forces bipolar for that measurement
// - amplifier offset test skips chopping so offset stays in result
// - select 4 forces bipolar and negative supply input, result 0000h
// - select 5 forces bipolar and positive supply input, result FFF0h
// - switch mode codes: 1 short, 2 open, 5 odd wire, 6 even wire
// - any nonzero switch mode forces alternate path; modes 1, 2, 5 and 6 enable comparisons
// - switch modes suppress over, under and mismatch alert comparisons
// - clearing switch mode restores every overridden setting automatically
// - short mode zeroes upper measure enables, all switches, sets alternate path
// - short mode flags a switch whose voltage is below short threshold
// - open mode forces bipolar, alternate path, mirrors switch enables
// - open mode flags enabled switch outside low and high thresholds
// - a violation sets the flag bit of that switch position
// - sense-wire modes close alternate switches and check both thresholds
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "adc_selftest_result_defs.svh"
module adc_and_balance_switch_diagnostics
    import adc_selftest_result_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             acq_start,
    input  wire logic        acq_done,
    input  wire logic        sample_valid,
    input  wire logic [3:0]  sample_channel,
    input  wire logic [15:0] sample_volts,
    input  wire logic        selftest_result_valid,
    input  wire logic [15:0] selftest_result_data,
    output logic [14:0]      measure_enable_out,
    output logic [11:0]      switch_enable_out,
    output logic             alt_path_out,
    output logic             bipolar_out,
    output logic             alert_compare_enable,
    output selftest_sel_t    selftest_source,
    output logic             selftest_result_bipolar,
    output logic             amp_inputs_short,
    output logic             chop_skip
);
    selftest_result_cmp_if cmp ();

    // software-visible settings
    selftest_sel_t sel_r, sel_nxt;
    switch_mode_t  mode_r, mode_nxt;
    logic [14:0]   meas_r, meas_nxt;
    logic [11:0]   bal_r, bal_nxt;
    logic          alt_cfg_r, alt_cfg_nxt;
    logic          pol_cfg_r, pol_cfg_nxt;
    logic [15:0]   short_r, short_nxt;
    logic [15:0]   low_r, low_nxt;
    logic [15:0]   high_r, high_nxt;
    logic [11:0]   flags_r, flags_nxt;
    logic [15:0]   result_r, result_nxt;
    acq_state_t    state_r, state_nxt;
    // bus slave state
    logic          aw_held_r, aw_held_nxt;
    logic [7:0]    awaddr_r, awaddr_nxt;
    logic          w_held_r, w_held_nxt;
    logic [31:0]   wdata_r, wdata_nxt;
    logic [3:0]    wstrb_r, wstrb_nxt;
    logic          awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0]    bresp_nxt, rresp_nxt;
    logic [31:0]   rdata_nxt;
    logic          start_nxt;
    logic [31:0]   wmerge;
    logic [31:0]   wclr;
    logic [14:0]   eff_meas_nxt;
    logic [11:0]   eff_bal_nxt;
    logic          eff_alt_nxt, eff_pol_nxt;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) v[8*i +: 8] = new_v[8*i +: 8];
        end
        return v;
    endfunction : apply_strb

    function automatic logic is_mapped(input logic [7:0] a);
        return a[7:2] < `REG_WORDS;
    endfunction : is_mapped

    // read mux, also the base for byte-lane merges on write
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        unique case ({a[7:2], 2'b00})
            `OFS_SELFTEST_SELECT:  v[2:0] = sel_r;
            `OFS_SWITCH_SELFTEST_RESULT_MODE: v[2:0] = mode_r;
            `OFS_MEASURE_ENABLE:   v[14:0] = meas_r;
            `OFS_BALANCE_ENABLE:   v[11:0] = bal_r;
            `OFS_SELFTEST_CONFIG:  v[`ALT_PATH_BIT] = alt_cfg_r;
            `OFS_SCAN_CONTROL:     v[`POLARITY_BIT] = pol_cfg_r;
            `OFS_SHORT_THRESHOLD:  v[15:0] = short_r;
            `OFS_LOW_THRESHOLD:    v[15:0] = low_r;
            `OFS_HIGH_THRESHOLD:   v[15:0] = high_r;
            `OFS_FAULT_FLAGS:      v[11:0] = flags_r;
            `OFS_SELFTEST_RESULT:  v[15:0] = result_r;
            `OFS_ACQ_CONTROL: begin
                v[`BUSY_BIT] = state_r == ACQ_BUSY;
                v[`COMPARE_EN_BIT] = alert_compare_enable;
            end
            `OFS_EFFECTIVE_CONFIG: begin
                v[14:0] = measure_enable_out;
                v[`EFF_ALT_BIT] = alt_path_out;
                v[`EFF_BIPOLAR_BIT] = bipolar_out;
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction : rd_mux

    // write data merged into the old word; clear mask for write-one-to-clear
    always_comb wmerge = apply_strb(rd_mux(awaddr_r), wdata_r, wstrb_r); // re-merges on reg change
    assign wclr = apply_strb(32'h0, wdata_r, wstrb_r);

    // write channel: address and data taken in either order, then one response
    always_comb begin
        sel_nxt = sel_r;
        mode_nxt = mode_r;
        meas_nxt = meas_r;
        bal_nxt = bal_r;
        alt_cfg_nxt = alt_cfg_r;
        pol_cfg_nxt = pol_cfg_r;
        short_nxt = short_r;
        low_nxt = low_r;
        high_nxt = high_r;
        start_nxt = 1'b0;
        aw_held_nxt = aw_held_r;
        awaddr_nxt = awaddr_r;
        w_held_nxt = w_held_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = s_axi_bvalid && !s_axi_bready;
        bresp_nxt = s_axi_bresp;
        if (s_axi_awready && s_axi_awvalid) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (aw_held_r && w_held_r && !s_axi_bvalid) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = is_mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            unique case ({awaddr_r[7:2], 2'b00})
                `OFS_SELFTEST_SELECT:  sel_nxt = selftest_sel_t'(wmerge[2:0]);
                `OFS_SWITCH_SELFTEST_RESULT_MODE: mode_nxt = switch_mode_t'(wmerge[2:0]);
                `OFS_MEASURE_ENABLE:   meas_nxt = wmerge[14:0];
                `OFS_BALANCE_ENABLE:   bal_nxt = wmerge[11:0];
                `OFS_SELFTEST_CONFIG:  alt_cfg_nxt = wmerge[`ALT_PATH_BIT];
                `OFS_SCAN_CONTROL:     pol_cfg_nxt = wmerge[`POLARITY_BIT];
                `OFS_SHORT_THRESHOLD:  short_nxt = wmerge[15:0];
                `OFS_LOW_THRESHOLD:    low_nxt = wmerge[15:0];
                `OFS_HIGH_THRESHOLD:   high_nxt = wmerge[15:0];
                // start is ignored while an acquisition runs
                `OFS_ACQ_CONTROL: start_nxt = wclr[`START_BIT] && state_r == ACQ_IDLE;
                default: start_nxt = 1'b0;
            endcase
        end
        awready_nxt = !aw_held_nxt && !bvalid_nxt;
        wready_nxt = !w_held_nxt && !bvalid_nxt;
    end

    // read channel: one read at a time, answer one cycle after the address
    always_comb begin
        rvalid_nxt = s_axi_rvalid && !s_axi_rready;
        rdata_nxt = s_axi_rdata;
        rresp_nxt = s_axi_rresp;
        if (s_axi_arready && s_axi_arvalid) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_mux(s_axi_araddr);
            rresp_nxt = is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    // acquisition, self-test capture and fault flags
    always_comb begin
        state_nxt = state_r;
        result_nxt = result_r;
        unique case (state_r)
            ACQ_IDLE: if (start_nxt) state_nxt = ACQ_BUSY;
            ACQ_BUSY: if (acq_done) state_nxt = ACQ_IDLE;
        endcase
        // no capture with select zero, so the last result stands
        if (state_r == ACQ_BUSY && selftest_result_valid && sel_r != ST_NONE) begin
            result_nxt = selftest_result_data;
        end
        flags_nxt = flags_r;
        if (aw_held_r && w_held_r && !s_axi_bvalid
            && {awaddr_r[7:2], 2'b00} == `OFS_FAULT_FLAGS) begin
            flags_nxt = flags_r & ~wclr[11:0];
        end
        // a fault in the clearing cycle survives the clear
        flags_nxt = flags_nxt | cmp.fault_set;
    end

    // overrides are computed from untouched user settings, so clearing restores them
    always_comb begin
        eff_meas_nxt = meas_r;
        eff_bal_nxt = bal_r;
        eff_alt_nxt = mode_r != SW_OFF ? 1'b1 : alt_cfg_r;
        eff_pol_nxt = pol_cfg_r;
        unique case (mode_r)
            SW_SHORT: begin
                eff_meas_nxt[14:12] = `UPPER_MEAS_FORCE;
                eff_bal_nxt = `SHORT_SWITCH_FORCE;
            end
            SW_OPEN: begin
                eff_meas_nxt = {`UPPER_MEAS_FORCE, bal_r};
                eff_pol_nxt = 1'b1;
            end
            SW_SENSE_ODD: eff_bal_nxt = `ODD_SWITCH_SET;
            SW_SENSE_EVEN: eff_bal_nxt = `EVEN_SWITCH_SET;
            default: eff_bal_nxt = bal_r;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_r <= ST_NONE;
            mode_r <= SW_OFF;
            meas_r <= `MEASURE_ENABLE_RST;
            bal_r <= `BALANCE_ENABLE_RST;
            alt_cfg_r <= 1'b0;
            pol_cfg_r <= 1'b0;
            short_r <= `THRESHOLD_RST;
            low_r <= `THRESHOLD_RST;
            high_r <= `HIGH_THRESHOLD_RST;
            flags_r <= 12'h000;
            result_r <= `RESULT_RST;
            state_r <= ACQ_IDLE;
            aw_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            w_held_r <= 1'b0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
            acq_start <= 1'b0;
            measure_enable_out <= `MEASURE_ENABLE_RST;
            switch_enable_out <= `BALANCE_ENABLE_RST;
            alt_path_out <= 1'b0;
            bipolar_out <= 1'b0;
            alert_compare_enable <= 1'b1;
            selftest_source <= ST_NONE;
            selftest_result_bipolar <= 1'b0;
            amp_inputs_short <= 1'b0;
            chop_skip <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            mode_r <= mode_nxt;
            meas_r <= meas_nxt;
            bal_r <= bal_nxt;
            alt_cfg_r <= alt_cfg_nxt;
            pol_cfg_r <= pol_cfg_nxt;
            short_r <= short_nxt;
            low_r <= low_nxt;
            high_r <= high_nxt;
            flags_r <= flags_nxt;
            result_r <= result_nxt;
            state_r <= state_nxt;
            aw_held_r <= aw_held_nxt;
            awaddr_r <= awaddr_nxt;
            w_held_r <= w_held_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
            acq_start <= start_nxt;
            measure_enable_out <= eff_meas_nxt;
            switch_enable_out <= eff_bal_nxt;
            alt_path_out <= eff_alt_nxt;
            bipolar_out <= eff_pol_nxt;
            alert_compare_enable <= mode_r == SW_OFF;
            selftest_source <= sel_r;
            selftest_result_bipolar <= sel_r inside {ST_AMP_OFFSET, ST_ZERO_SCALE, ST_FULL_SCALE};
            amp_inputs_short <= sel_r == ST_AMP_OFFSET;
            chop_skip <= sel_r == ST_AMP_OFFSET;
        end
    end

    // comparator sees samples only during a host-started acquisition
    assign cmp.sample_valid = sample_valid && state_r == ACQ_BUSY;
    assign cmp.sample_channel = sample_channel;
    assign cmp.sample_volts = sample_volts;
    assign cmp.mode = mode_r;
    assign cmp.short_thr = short_r;
    assign cmp.low_thr = low_r;
    assign cmp.high_thr = high_r;
    assign cmp.switch_enable = bal_r;

    switch_fault_check u_check (
        .clk     (clk),
        .reset_n (reset_n),
        .cmp     (cmp)
    );

    property p_alt_forced;
        @(posedge clk) disable iff (!reset_n) mode_r != SW_OFF |=> alt_path_out;
    endproperty
    a_alt_forced: assert property (p_alt_forced) else $error("alt path not forced");

    property p_alert_off;
        @(posedge clk) disable iff (!reset_n)
        mode_r != SW_OFF |=> !alert_compare_enable ##1 (mode_r == SW_OFF || !alert_compare_enable);
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("alerts not suppressed");

    property p_short_cfg;
        @(posedge clk) disable iff (!reset_n)
        mode_r == SW_SHORT |=> switch_enable_out == 12'h000 && measure_enable_out[14:12] == 3'h0;
    endproperty
    a_short_cfg: assert property (p_short_cfg) else $error("short override wrong");

    property p_open_cfg;
        @(posedge clk) disable iff (!reset_n)
        mode_r == SW_OPEN |=> measure_enable_out == {3'h0, $past(bal_r)} && bipolar_out;
    endproperty
    a_open_cfg: assert property (p_open_cfg) else $error("open override wrong");

    property p_restore;
        @(posedge clk) disable iff (!reset_n)
        mode_r != SW_OFF ##1 mode_r == SW_OFF |=> measure_enable_out == $past(meas_r)
            && switch_enable_out == $past(bal_r) && alt_path_out == $past(alt_cfg_r);
    endproperty
    a_restore: assert property (p_restore) else $error("settings not restored");

    property p_sense_odd;
        @(posedge clk) disable iff (!reset_n) mode_r == SW_SENSE_ODD |=> switch_enable_out == 12'h555;
    endproperty
    a_sense_odd: assert property (p_sense_odd) else $error("odd switches not closed");

    property p_capture;
        @(posedge clk) disable iff (!reset_n)
        state_r == ACQ_BUSY && selftest_result_valid && sel_r != ST_NONE |=> result_r == $past(selftest_result_data);
    endproperty
    a_capture: assert property (p_capture) else $error("self-test result lost");

    property p_hold;
        @(posedge clk) disable iff (!reset_n) sel_r == ST_NONE |=> $stable(result_r);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without self-test");

    property p_amp;
        @(posedge clk) disable iff (!reset_n)
        sel_r == ST_AMP_OFFSET |=> amp_inputs_short && chop_skip && selftest_result_bipolar;
    endproperty
    a_amp: assert property (p_amp) else $error("offset test setup wrong");

    property p_flag_kept;
        @(posedge clk) disable iff (!reset_n)
        cmp.fault_set != 12'h000 |=> (flags_r & $past(cmp.fault_set)) == $past(cmp.fault_set);
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("fault flag lost");
endmodule : adc_and_balance_switch_diagnostics

// ==== front_end_model.sv ====
// behavioural acquisition front end that answers each start pulse
`timescale 1ns/10ps
module front_end_model (
    input  wire logic        clk,
    input  wire logic        acq_start,
    input  wire logic [15:0] volts_base,
    input  wire logic [15:0] selftest_result_value,
    output logic             acq_done,
    output logic             sample_valid,
    output logic [3:0]       sample_channel,
    output logic [15:0]      sample_volts,
    output logic             selftest_result_valid,
    output logic [15:0]      selftest_result_data
);
    initial {acq_done, sample_valid, selftest_result_valid, sample_channel, sample_volts, selftest_result_data} = '0;
    // idle data lines toggle so a stale value never looks valid
    always @(posedge clk) begin
        sample_volts <= ~sample_volts;
        selftest_result_data    <= ~selftest_result_data;
        if (acq_start) begin
            for (int i = 0; i < 12; i++) begin
                {sample_valid, sample_channel} <= {1'b1, i[3:0]};
                sample_volts <= volts_base + 16'(i * 256);
                @(posedge clk);
            end
            {sample_valid, selftest_result_valid, selftest_result_data} <= {2'b01, selftest_result_value};
            @(posedge clk);
            {selftest_result_valid, acq_done} <= 2'b01;
            @(posedge clk);
            acq_done <= 1'b0;
        end
    end
endmodule : front_end_model

// ==== tb.sv ====
// self-checking bench for the diagnostic sequencer
`timescale 1ns/10ps
`include "adc_selftest_result_defs.svh"
module tb;
    import adc_selftest_result_pkg::*;
    logic clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, acq_start, acq_done, sample_valid, selftest_result_valid;
    logic alt_path_out, bipolar_out, alert_compare_enable, selftest_result_bipolar, amp_inputs_short, chop_skip;
    logic [7:0]    s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]   s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0]    s_axi_wstrb = 4'hf, sample_channel;
    logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
    logic [15:0]   sample_volts, selftest_result_data, vb = 0, dv = 0, st, lo, hi, pv;
    logic [14:0]   measure_enable_out;
    logic [11:0]   switch_enable_out, en;
    logic [2:0]    modes[4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    selftest_sel_t selftest_source;
    int            seed = 21, err_total = 0, n_tests = 0;
    // 25 ns period
    always #12.5 clk = ~clk;
    adc_and_balance_switch_diagnostics dut (.*);
    front_end_model fe (.clk, .acq_start, .volts_base(vb), .selftest_result_value(dv), .acq_done,
        .sample_valid, .sample_channel, .sample_volts, .selftest_result_valid, .selftest_result_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic limit(input int n);
        if (n >= 50) begin
            err_total++;
            final_report;
        end
    endtask : limit
    // one edge first, so back-to-back calls never drive a line twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && n < 50);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
        limit(n);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n = 0;
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid && n < 50);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
        limit(n);
    endtask : rd
    // start, then poll busy with a bound
    task automatic acq;
        int n = 0;
        wr(`OFS_ACQ_CONTROL, 1);
        do begin
            rd(`OFS_ACQ_CONTROL, d);
            n++;
        end while (d[0] !== 1'b0 && n < 50);
        limit(n);
    endtask : acq
    function automatic logic [11:0] flags(input logic [2:0] m);
        logic [15:0] v;
        for (int i = 0; i < 12; i++) begin
            v = vb + 16'(i * 256);
            flags[i] = (m == 1) ? v < st : (m == 2 ? en[i] : 1'b1) && (v > hi || v < lo);
        end
    endfunction : flags
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        rd(`OFS_HIGH_THRESHOLD, d);
        chk(d, 32'hffff);
        chk(resp, `RESP_OKAY);
        rd(8'h40, d);
        chk(d, 0);
        chk(resp, `RESP_SLVERR);
        wr(8'h40, 1);
        chk(resp, `RESP_SLVERR);
        for (int s = 1; s < 6; s++) begin
            dv <= (s == 4) ? 16'h0 : (s == 5) ? 16'hfff0 : (s == 2) ? 16'h7628
                : (s == 1) ? 16'h3ef8 + 16'({$random(seed)} % 317) : 16'($random(seed));
            wr(`OFS_SELFTEST_SELECT, s);
            chk(resp, `RESP_OKAY);
            acq;
            rd(`OFS_SELFTEST_RESULT, d);
            chk(d, dv);
            // host-side readings: reference in mV and its window, supply in mV
            if (s == 1) chk((d[15:2] * 5000 / 16384) inside {[1229:1253]}, 1);
            if (s == 1) chk(d >= 32'h3ef8 && d <= 32'h4034, 1);
            if (s == 2) chk(13842 * 16384 / 13 / d[15:2], 2306);
            chk({selftest_source, selftest_result_bipolar}, {s[2:0], s > 2});
            chk({amp_inputs_short, chop_skip}, {2{s == 3}});
        end
        pv = dv;
        dv <= ~dv;
        wr(`OFS_SELFTEST_SELECT, 0);
        acq;
        rd(`OFS_SELFTEST_RESULT, d);
        chk(d, pv);
        {vb, en} = {1'b0, 15'($random(seed)), 12'($random(seed))};
        {st, lo, hi} = {vb + 16'h0500, vb + 16'h0400, vb + 16'h0800};
        wr(`OFS_MEASURE_ENABLE, 32'h7fff);
        wr(`OFS_BALANCE_ENABLE, en);
        wr(`OFS_SHORT_THRESHOLD, st);
        wr(`OFS_LOW_THRESHOLD, lo);
        wr(`OFS_HIGH_THRESHOLD, hi);
        foreach (modes[k]) begin
            wr(`OFS_FAULT_FLAGS, 32'hfff);
            wr(`OFS_SWITCH_SELFTEST_RESULT_MODE, modes[k]);
            repeat (2) @(posedge clk);
            chk({alt_path_out, alert_compare_enable}, 2'b10);
            if (modes[k] == 1) chk({measure_enable_out[14:12], switch_enable_out}, 0);
            if (modes[k] == 2) chk({bipolar_out, measure_enable_out}, {4'h8, en});
            if (modes[k] > 4) chk(switch_enable_out, modes[k] == 5 ? 12'h555 : 12'haaa);
            if (modes[k] > 4) repeat (4000) @(posedge clk);
            acq;
            rd(`OFS_FAULT_FLAGS, d);
            chk(d, flags(modes[k]));
            wr(`OFS_SWITCH_SELFTEST_RESULT_MODE, 0);
            repeat (2) @(posedge clk);
            chk({alt_path_out, bipolar_out, alert_compare_enable}, 3'h1);
            chk({measure_enable_out, switch_enable_out}, {15'h7fff, en});
        end
        final_report;
    end
endmodule : tb
